// [rtl/hdlc_cfg_pkg.sv]
// Register map, field positions, line patterns and carriers for the HDLC control block
package hdlc_cfg_pkg;
    localparam int FIFO_DEPTH = 64;
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_TXC = 4'h1;
    localparam logic [3:0] REG_TXSTAT = 4'h2;
    localparam logic [3:0] REG_DATA = 4'h3;
    localparam logic [3:0] REG_BANK_LO = 4'hb;
    localparam logic [3:0] REG_BANK_HI = 4'hd;
    localparam logic [3:0] REG_IRQ = 4'hf;
    localparam logic [2:0] BANK_REGS = 3'h3;
    localparam logic [7:0] CFG_RST = 8'h40;
    localparam logic [7:0] TXC_RST = 8'h00;
    localparam int CFG_LEVEL = 0;
    localparam int CFG_IRQPOL = 1;
    localparam int CFG_FLAGS = 2;
    localparam int CFG_BLOCK = 3;
    localparam int CFG_SHADOW = 4;
    localparam int CFG_SEDGE = 5;
    localparam int CFG_SPOL = 6;
    localparam int CFG_TDM = 7;
    localparam int TXC_THR_W = 6;
    localparam int TXC_ABORT = 6;
    localparam int TXC_CLOSE = 7;
    localparam int TXS_TED = 7;
    localparam int IRQ_TX = 1;
    localparam int IRQ_RX = 3;
    // Line patterns held LSB first, the order in which they leave
    localparam logic [7:0] PAT_FLAG = 8'h7e;
    localparam logic [7:0] PAT_IDLE = 8'hff;
    localparam logic [7:0] PAT_ABORT = 8'hfe;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [3:0] SLOT_BITS = 4'h8;
    localparam logic [3:0] SLOT_FIRST = 4'h1;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [4:0] CRC_BITS = 5'h10;
    localparam logic [4:0] BIT_LAST = 5'h01;

    typedef struct packed {
        logic close;
        logic abort;
        logic [7:0] data;
    } tx_entry_s;

    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic bm_addr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } host_req_s;
endpackage

// [rtl/hdlc_config_tx_control.sv]
// Configuration and transmit control registers with tagged transmit queue and HDLC serializer
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Non-level mode: reading status clears it; a bit re-sets only on a new rising cause
// - Level mode: transmit and receive status bits and interrupt follow their causes
// - Interrupt output is active high when polarity bit is 1, else active low
// - With nothing to send, line carries flags or all-ones per the idle fill bit
// - Block transfer bit plus address bit 6 sends all writes to the queue
// - Shadow bank bit steers register numbers 11 to 13 to alternate storage
// - Frame sync sampled on rising or falling link clock edge per sample edge bit
// - Frame start is rising or falling sync edge per sync polarity bit
// - Slot enable limits sending to the 8-bit slot after frame start
// - Reset: configuration reads 0x40, transmitter control reads zero
// - Space event when free slots reach threshold; zero threshold means queue empty
// - Abort tags the last queued byte; abort pattern replaces it, a whole byte
// - Abort bit reads back as written; writing 0 keeps an existing tag
// - Close tags the last queued byte; CRC and closing flag follow it
// - Close bit reads back as written; writing 0 keeps an existing tag
// - A new frame needs no write of 0 to the close bit
// - Transmit status reports free queue bytes in a 7-bit field
module hdlc_config_tx_control #(
    parameter int FIFO_DEPTH = hdlc_cfg_pkg::FIFO_DEPTH
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire hdlc_cfg_pkg::host_req_s host_req_in,
    input wire logic rx_level_cond_in,
    output logic [7:0] host_rdata_out,
    output logic irq_out,
    input wire logic tx_bit_clock_in,
    input wire logic frame_sync_in,
    output logic tx_data_out,
    output logic tx_slot_out
);
    import hdlc_cfg_pkg::*;

    localparam int AW = $clog2(FIFO_DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(FIFO_DEPTH);

    typedef enum logic [4:0] {
        PH_IDLE = 5'h01,
        PH_FLAG = 5'h02,
        PH_DATA = 5'h04,
        PH_CRC = 5'h08,
        PH_ABORT = 5'h10
    } phase_e;

    function automatic logic [2:0] bank_idx(input logic [3:0] a, input logic shadow_bank_select);
        bank_idx = 3'(a - REG_BANK_LO) + (shadow_bank_select ? BANK_REGS : 3'h0);
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
    endfunction

    // Core domain state
    logic [7:0] cfg_q, cfg_d, txc_q, txc_d, rdata_q, rdata_d, irq_st_q, irq_st_d;
    logic [7:0] bank_q [0:5];
    logic [7:0] bank_d [0:5];
    tx_entry_s mem_q [0:FIFO_DEPTH-1];
    logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d, last_ptr;
    logic [AW:0] count_q, count_d, free;
    logic irq_q, irq_d, te_prev_q, rx_prev_q, te_cond;
    logic req_meta_q, req_c_q, req_seen_q, req_seen_d, ack_q, ack_d;
    tx_entry_s hold_q, hold_d, tag_val;
    logic hold_v_q, hold_v_d;
    logic wr_c, rd_c, blk, push, pop, tag_c, in_bank;

    // Link domain state
    logic lrst_meta_q, lrst_q, ack_meta_q, ack_l_q, fs_pos_q, fs_neg_q;
    logic [7:0] cfg_meta_q, cfg_l_q;
    logic req_q, req_d, seen_q, seen_d, nv_q, nv_d, fs_prev_q, fstart, fs_sel, slot_ok;
    tx_entry_s next_q, next_d;
    logic [3:0] slot_q, slot_d;
    phase_e ph_q, ph_d;
    logic close_q, close_d, infr_q, infr_d, bit_q, bit_d, act_q, act_d;
    logic [15:0] sh_q, sh_d, crc_q, crc_d;
    logic [4:0] cnt_q, cnt_d;
    logic [2:0] ones_q, ones_d;

    assign host_rdata_out = rdata_q;
    assign irq_out = irq_q;
    assign tx_data_out = bit_q;
    assign tx_slot_out = act_q;

    always_comb begin
        wr_c = host_req_in.sel & host_req_in.wr;
        rd_c = host_req_in.sel & host_req_in.rd;
        blk = cfg_q[CFG_BLOCK] & host_req_in.bm_addr;
        in_bank = (host_req_in.addr >= REG_BANK_LO) && (host_req_in.addr <= REG_BANK_HI);
        free = DEPTH_C - count_q;
        te_cond = (txc_q[TXC_THR_W-1:0] == '0) ? (count_q == '0)
                : (free >= (AW+1)'(txc_q[TXC_THR_W-1:0]));
        push = wr_c & (blk | (host_req_in.addr == REG_DATA)) & (count_q != DEPTH_C);
        pop = (req_c_q != req_seen_q) & (count_q != '0);
        last_ptr = wr_ptr_q - 1'b1;
        tag_c = wr_c & !blk & (host_req_in.addr == REG_TXC) & (count_q != '0);
        tag_val = mem_q[last_ptr];
        tag_val.close = tag_val.close | host_req_in.wdata[TXC_CLOSE];
        tag_val.abort = tag_val.abort | host_req_in.wdata[TXC_ABORT];
        cfg_d = cfg_q;
        txc_d = txc_q;
        bank_d = bank_q;
        if (wr_c && !blk) begin
            case (host_req_in.addr)
                REG_CFG: cfg_d = host_req_in.wdata;
                REG_TXC: txc_d = host_req_in.wdata;
                default: begin
                    if (in_bank) begin
                        bank_d[bank_idx(host_req_in.addr, cfg_q[CFG_SHADOW])] = host_req_in.wdata;
                    end
                end
            endcase
        end
        rdata_d = rdata_q;
        if (rd_c) begin
            if (blk) begin
                rdata_d = '0; // Receive queue lives outside this block
            end else begin
                case (host_req_in.addr)
                    REG_CFG: rdata_d = cfg_q;
                    REG_TXC: rdata_d = txc_q;
                    REG_TXSTAT: rdata_d = {te_cond, TXS_TED'(free)};
                    REG_IRQ: rdata_d = irq_st_q;
                    default: rdata_d = in_bank ? bank_q[bank_idx(host_req_in.addr, cfg_q[CFG_SHADOW])] : '0;
                endcase
            end
        end
        irq_st_d = '0;
        if (cfg_q[CFG_LEVEL]) begin
            irq_st_d[IRQ_TX] = te_cond;
            irq_st_d[IRQ_RX] = rx_level_cond_in;
        end else begin
            // Set wins over a read in the same cycle
            irq_st_d = (rd_c && !blk && host_req_in.addr == REG_IRQ) ? '0 : irq_st_q;
            irq_st_d[IRQ_TX] = irq_st_d[IRQ_TX] | (te_cond & ~te_prev_q);
            irq_st_d[IRQ_RX] = irq_st_d[IRQ_RX] | (rx_level_cond_in & ~rx_prev_q);
        end
        irq_d = cfg_q[CFG_IRQPOL] ? (|irq_st_q) : ~(|irq_st_q);
        wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
        count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
        req_seen_d = req_seen_q;
        ack_d = ack_q;
        hold_d = hold_q;
        hold_v_d = hold_v_q;
        if (req_c_q != req_seen_q) begin
            req_seen_d = req_c_q;
            ack_d = ~ack_q;
            hold_d = mem_q[rd_ptr_q];
            hold_v_d = pop;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            cfg_q <= CFG_RST;
            txc_q <= TXC_RST;
            rdata_q <= '0;
            irq_st_q <= '0;
            irq_q <= 1'b1;
            te_prev_q <= 1'b0;
            rx_prev_q <= 1'b0;
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            req_meta_q <= 1'b0;
            req_c_q <= 1'b0;
            req_seen_q <= 1'b0;
            ack_q <= 1'b0;
            hold_q <= '0;
            hold_v_q <= 1'b0;
            for (int i = 0; i < 6; i++) begin
                bank_q[i] <= '0;
            end
        end else if (ce_in) begin
            cfg_q <= cfg_d;
            txc_q <= txc_d;
            rdata_q <= rdata_d;
            irq_st_q <= irq_st_d;
            irq_q <= irq_d;
            te_prev_q <= te_cond;
            rx_prev_q <= rx_level_cond_in;
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            req_meta_q <= req_q;
            req_c_q <= req_meta_q;
            req_seen_q <= req_seen_d;
            ack_q <= ack_d;
            hold_q <= hold_d;
            hold_v_q <= hold_v_d;
            bank_q <= bank_d;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (ce_in && push) begin
            mem_q[wr_ptr_q] <= '{close: 1'b0, abort: 1'b0, data: host_req_in.wdata};
        end else if (ce_in && tag_c) begin
            mem_q[last_ptr] <= tag_val;
        end
    end

    // Link side: frame sync on both edges, selected below
    always_ff @(negedge tx_bit_clock_in) begin
        fs_neg_q <= frame_sync_in;
    end

    always_comb begin
        fs_sel = cfg_l_q[CFG_SEDGE] ? fs_pos_q : fs_neg_q;
        fstart = cfg_l_q[CFG_SPOL] ? (fs_sel & ~fs_prev_q) : (~fs_sel & fs_prev_q);
        slot_d = fstart ? SLOT_FIRST : ((slot_q < SLOT_BITS) ? slot_q + 1'b1 : slot_q);
        slot_ok = !cfg_l_q[CFG_TDM] | fstart | (slot_q < SLOT_BITS);
        req_d = req_q;
        seen_d = seen_q;
        next_d = next_q;
        nv_d = nv_q;
        if (ack_l_q != seen_q) begin
            seen_d = ack_l_q;
            nv_d = hold_v_q;
            next_d = hold_q;
        end else if (!nv_q && req_q == seen_q) begin
            req_d = ~req_q;
        end
        ph_d = ph_q;
        close_d = close_q;
        infr_d = infr_q;
        bit_d = 1'b1;
        act_d = slot_ok;
        sh_d = sh_q;
        crc_d = crc_q;
        cnt_d = cnt_q;
        ones_d = ones_q;
        if (slot_ok && ones_q == STUFF_RUN) begin
            bit_d = 1'b0;
            ones_d = '0;
        end else if (slot_ok) begin
            bit_d = sh_q[0];
            sh_d = sh_q >> 1;
            cnt_d = cnt_q - 1'b1;
            case (ph_q)
                PH_DATA: begin
                    crc_d = crc_step(crc_q, sh_q[0]);
                    ones_d = sh_q[0] ? ones_q + 1'b1 : '0;
                end
                PH_CRC: ones_d = sh_q[0] ? ones_q + 1'b1 : '0;
                default: ones_d = '0;
            endcase
            if (cnt_q == BIT_LAST) begin
                cnt_d = BYTE_BITS;
                if (ph_q == PH_DATA && close_q) begin
                    ph_d = PH_CRC;
                    sh_d = ~crc_d;
                    cnt_d = CRC_BITS;
                end else if (ph_q == PH_CRC) begin
                    ph_d = PH_FLAG;
                    sh_d = {8'h00, PAT_FLAG};
                    infr_d = 1'b0;
                end else if (nv_q && next_q.abort) begin
                    // Abort outranks a close on the same byte
                    ph_d = PH_ABORT;
                    sh_d = {8'h00, PAT_ABORT};
                    infr_d = 1'b0;
                    nv_d = 1'b0;
                end else if (nv_q && (infr_q || ph_q == PH_FLAG)) begin
                    ph_d = PH_DATA;
                    sh_d = {8'h00, next_q.data};
                    close_d = next_q.close;
                    nv_d = 1'b0;
                    infr_d = 1'b1;
                    if (!infr_q) begin
                        crc_d = CRC_INIT;
                    end
                end else if (nv_q) begin
                    ph_d = PH_FLAG;
                    sh_d = {8'h00, PAT_FLAG};
                end else if (infr_q) begin
                    // Queue ran dry mid-frame: the frame cannot close cleanly
                    ph_d = PH_ABORT;
                    sh_d = {8'h00, PAT_ABORT};
                    infr_d = 1'b0;
                end else begin
                    ph_d = cfg_l_q[CFG_FLAGS] ? PH_FLAG : PH_IDLE;
                    sh_d = {8'h00, cfg_l_q[CFG_FLAGS] ? PAT_FLAG : PAT_IDLE};
                end
            end
        end
    end

    always_ff @(posedge tx_bit_clock_in) begin
        lrst_meta_q <= sys_rst_in;
        lrst_q <= lrst_meta_q;
        ack_meta_q <= ack_q;
        ack_l_q <= ack_meta_q;
        // Configuration is quasi-static, so a plain two-stage copy is enough
        cfg_meta_q <= cfg_q;
        cfg_l_q <= cfg_meta_q;
        fs_pos_q <= frame_sync_in;
        if (lrst_q) begin
            req_q <= 1'b0;
            seen_q <= 1'b0;
            next_q <= '0;
            nv_q <= 1'b0;
            fs_prev_q <= 1'b0;
            slot_q <= SLOT_BITS;
            ph_q <= PH_IDLE;
            close_q <= 1'b0;
            infr_q <= 1'b0;
            bit_q <= 1'b1;
            act_q <= 1'b0;
            sh_q <= {8'h00, PAT_IDLE};
            crc_q <= CRC_INIT;
            cnt_q <= BYTE_BITS;
            ones_q <= '0;
        end else begin
            req_q <= req_d;
            seen_q <= seen_d;
            next_q <= next_d;
            nv_q <= nv_d;
            fs_prev_q <= fs_sel;
            slot_q <= slot_d;
            ph_q <= ph_d;
            close_q <= close_d;
            infr_q <= infr_d;
            bit_q <= bit_d;
            act_q <= act_d;
            sh_q <= sh_d;
            crc_q <= crc_d;
            cnt_q <= cnt_d;
            ones_q <= ones_d;
        end
    end

    a_read_clears_status: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        ce_in && rd_c && !blk && host_req_in.addr == REG_IRQ && !cfg_q[CFG_LEVEL]
        && !(te_cond && !te_prev_q) && !(rx_level_cond_in && !rx_prev_q) |=> irq_st_q == '0)
        else $error("status not cleared by read");
    a_level_follows_cause: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        ce_in && cfg_q[CFG_LEVEL] |=> irq_st_q[IRQ_RX] == $past(rx_level_cond_in))
        else $error("level status does not follow cause");
    a_irq_pin_polarity: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        ce_in |=> irq_out == ($past(cfg_q[CFG_IRQPOL]) ~^ (|$past(irq_st_q))))
        else $error("interrupt polarity wrong");
    a_reset_values: assert property (@(posedge core_clk_in)
        $past(sys_rst_in) && !sys_rst_in |-> cfg_q == CFG_RST && txc_q == TXC_RST)
        else $error("reset values wrong");
    a_free_count_read: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        ce_in && rd_c && !blk && host_req_in.addr == REG_TXSTAT
        |=> host_rdata_out[TXS_TED-1:0] == TXS_TED'(DEPTH_C - $past(count_q)))
        else $error("free count wrong");
    a_empty_space_event: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        ce_in && rd_c && !blk && host_req_in.addr == REG_TXSTAT && count_q == '0
        |=> host_rdata_out[TXS_TED])
        else $error("space event missing on empty queue");
    a_close_tag_sticky: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        ce_in && tag_c && !pop && mem_q[last_ptr].close |=> mem_q[$past(last_ptr)].close)
        else $error("close tag lost");
    a_abort_tag_set: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        ce_in && tag_c && host_req_in.wdata[TXC_ABORT] |=> mem_q[$past(last_ptr)].abort
        && txc_q[TXC_ABORT])
        else $error("abort tag not attached");
    a_shadow_bank_write: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        ce_in && wr_c && !blk && in_bank && cfg_q[CFG_SHADOW]
        |=> bank_q[$past(bank_idx(host_req_in.addr, 1'b1))] == $past(host_req_in.wdata))
        else $error("alternate bank not written");
    a_tdm_slot_quiet: assert property (@(posedge tx_bit_clock_in) disable iff (lrst_q)
        cfg_l_q[CFG_TDM] && slot_q == SLOT_BITS && !fstart |=> !tx_slot_out && tx_data_out)
        else $error("sent outside slot");
endmodule
`default_nettype wire

// [test/hdlc_config_tx_control_tb.sv]
// Self-checking bench for the HDLC configuration and transmit control block
`timescale 1ns/1ps
`default_nettype none
module hdlc_config_tx_control_tb;
    import hdlc_cfg_pkg::*;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic rx_level_cond_in = 1'b0;
    host_req_s req = '0;
    logic [7:0] host_rdata_out;
    logic irq_out;
    logic link_clk;
    logic frame_sync;
    logic tx_data;
    logic tx_slot;
    logic run = 1'b1;
    logic sync_pol = 1'b1;
    logic [7:0] window;
    int slot_bits;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    hdlc_config_tx_control hdlc_config_tx_control_i (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(1'b1),
        .host_req_in(req),
        .rx_level_cond_in(rx_level_cond_in),
        .host_rdata_out(host_rdata_out),
        .irq_out(irq_out),
        .tx_bit_clock_in(link_clk),
        .frame_sync_in(frame_sync),
        .tx_data_out(tx_data),
        .tx_slot_out(tx_slot)
    );
    hdlc_link_model hdlc_link_model_i (
        .run_in(run),
        .sync_pol_in(sync_pol),
        .data_in(tx_data),
        .slot_in(tx_slot),
        .bit_clk_out(link_clk),
        .sync_out(frame_sync),
        .window_out(window),
        .slot_bits_out(slot_bits)
    );

    task automatic results();
        $display("Comparisons: %0d mismatches: %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask
    // One access: held across the taking edge, then a spare cycle before the next
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        req.sel = 1'b1;
        req.wr = w;
        req.rd = ~w;
        req.addr = a;
        req.wdata = d;
        @(negedge core_clk_in);
        req.sel = 1'b0;
        req.wr = 1'b0;
        req.rd = 1'b0;
        @(negedge core_clk_in);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string msg);
        bus(1'b0, a, 8'h00);
        chk(host_rdata_out, exp, msg);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    // Bounded watch of the captured line bits for a byte pattern
    task automatic seek(input logic [7:0] pat, input string msg);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 600 && !hit; i++) begin
            @(negedge link_clk);
            hit = (window === pat);
        end
        chk({7'h00, hit}, 8'h01, msg);
        idle(1);
    endtask
    function automatic logic [7:0] st(input logic ted, input int used);
        return {ted, 7'(FIFO_DEPTH - used)};
    endfunction

    task automatic t_reset();
        rd(REG_CFG, CFG_RST, "config reset");
        rd(REG_TXC, TXC_RST, "control reset");
        wr(REG_TXC, 8'h80);
        rd(REG_TXC, 8'h80, "close readback");
        wr(REG_TXC, 8'h40);
        rd(REG_TXC, 8'h40, "abort readback");
        wr(REG_TXC, 8'h00);
        rd(REG_TXC, 8'h00, "control cleared");
    endtask
    task automatic t_bank();
        for (int i = 0; i < 3; i++) begin
            wr(REG_CFG, 8'h50);
            wr(REG_BANK_LO + 4'(i), 8'ha0 + 8'(i));
            wr(REG_CFG, 8'h40);
            wr(REG_BANK_LO + 4'(i), 8'h50 + 8'(i));
            rd(REG_BANK_LO + 4'(i), 8'h50 + 8'(i), "primary bank");
            wr(REG_CFG, 8'h50);
            rd(REG_BANK_LO + 4'(i), 8'ha0 + 8'(i), "shadow bank");
        end
        wr(REG_CFG, 8'h40);
    endtask
    task automatic t_irq();
        wr(REG_CFG, 8'h43);
        rx_level_cond_in = 1'b1;
        idle(3);
        rd(REG_IRQ, 8'h0a, "level status set");
        chk({7'h00, irq_out}, 8'h01, "irq active high");
        rx_level_cond_in = 1'b0;
        idle(3);
        rd(REG_IRQ, 8'h02, "level status follows");
        wr(REG_CFG, 8'h41);
        idle(3);
        chk({7'h00, irq_out}, 8'h00, "irq active low");
        wr(REG_CFG, 8'h40);
        bus(1'b0, REG_IRQ, 8'h00);
        idle(2);
        rd(REG_IRQ, 8'h00, "no new cause");
        chk({7'h00, irq_out}, 8'h01, "irq released");
        rx_level_cond_in = 1'b1;
        idle(3);
        rd(REG_IRQ, 8'h08, "latched on new cause");
        rd(REG_IRQ, 8'h00, "cleared by read");
        rx_level_cond_in = 1'b0;
    endtask
    task automatic t_queue();
        run = 1'b0;
        rd(REG_TXSTAT, st(1'b1, 0), "empty queue");
        for (int i = 0; i < 3; i++) begin
            wr(REG_DATA, 8'h00);
        end
        rd(REG_TXSTAT, st(1'b0, 3), "zero threshold");
        wr(REG_TXC, 8'h3d);
        rd(REG_TXSTAT, st(1'b1, 3), "threshold met");
        wr(REG_TXC, 8'h3e);
        rd(REG_TXSTAT, st(1'b0, 3), "threshold missed");
        wr(REG_CFG, 8'h48);
        req.bm_addr = 1'b1;
        wr(REG_CFG, 8'h00);
        rd(REG_CFG, 8'h00, "block read");
        req.bm_addr = 1'b0;
        rd(REG_TXSTAT, st(1'b0, 4), "block write queued");
        rd(REG_CFG, 8'h48, "config untouched");
    endtask
    task automatic t_line();
        wr(REG_TXC, 8'h7e);
        wr(REG_TXC, 8'h3e);
        rd(REG_TXC, 8'h3e, "abort reads as written");
        wr(REG_CFG, 8'h44);
        run = 1'b1;
        seek(8'hfe, "abort sent");
        idle(100);
        rd(REG_TXSTAT, st(1'b1, 0), "queue drained");
        seek(8'h7e, "flag idle");
        wr(REG_CFG, 8'h40);
        seek(8'hff, "ones idle");
        wr(REG_CFG, 8'h44);
        wr(REG_DATA, 8'h3c);
        wr(REG_TXC, 8'hbe);
        seek(8'h3c, "frame data");
        wr(REG_DATA, 8'h5a);
        wr(REG_TXC, 8'hbe);
        seek(8'h5a, "next frame");
    endtask
    task automatic t_tdm();
        wr(REG_CFG, 8'hc0);
        idle(300);
        chk(8'(slot_bits), 8'h08, "slot on rising sync");
        sync_pol = 1'b0;
        wr(REG_CFG, 8'ha0);
        idle(300);
        chk(8'(slot_bits), 8'h08, "slot on falling sync");
        wr(REG_CFG, 8'h20);
        idle(300);
        chk(8'(slot_bits), 8'h20, "untimed bits");
    endtask

    initial begin
        forever #5 core_clk_in = ~core_clk_in;
    end
    // Whole run needs roughly 1300 cycles
    initial begin
        forever begin
            @(posedge core_clk_in);
            cycles++;
            if (cycles == 30000) begin
                fail_count++;
                $display("CHECK FAILED t=%0t run exceeded cycle limit", $time);
                results();
            end
        end
    end
    initial begin
        idle(10);
        chk({7'h00, irq_out}, 8'h01, "irq inactive in reset");
        sys_rst_in = 1'b0;
        t_reset();
        t_bank();
        t_irq();
        t_queue();
        t_line();
        t_tdm();
        results();
    end
endmodule
`default_nettype wire

// [test/hdlc_link_model.sv]
// Far-side model of the serial link: bit clock, frame sync and line capture
`timescale 1ns/1ps
`default_nettype none
module hdlc_link_model #(
    parameter int FRAME_BITS = 32
) (
    input wire logic run_in,
    input wire logic sync_pol_in,
    input wire logic data_in,
    input wire logic slot_in,
    output logic bit_clk_out,
    output logic sync_out,
    output logic [7:0] window_out,
    output int slot_bits_out
);
    int bit_pos = 0;
    int slot_cnt = 0;
    initial begin
        bit_clk_out = 1'b0;
        sync_out = 1'b0;
        window_out = 8'h00;
        slot_bits_out = 0;
    end
    // Clock stands still while stopped, so the transmit queue is not drained
    always begin
        if (run_in) begin
            #3 bit_clk_out = ~bit_clk_out;
        end else begin
            @(run_in);
        end
    end
    // Sync moves 1 ns after the rising edge so either sampling edge sees it settled
    always @(posedge bit_clk_out) begin
        bit_pos <= (bit_pos + 1) % FRAME_BITS;
        sync_out <= #1 (bit_pos == FRAME_BITS - 1) ? sync_pol_in : ~sync_pol_in;
        if (slot_in) begin
            window_out <= {data_in, window_out[7:1]};
        end
        if (bit_pos == FRAME_BITS - 1) begin
            slot_bits_out <= slot_cnt + int'(slot_in);
            slot_cnt <= 0;
        end else begin
            slot_cnt <= slot_cnt + int'(slot_in);
        end
    end
endmodule
`default_nettype wire
